// ---- verilog/codec_serial_port_framing.sv ----
`timescale 1ns/1ps

module word_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [CNT_W-1:0] count_ff;
	logic [PTR_W-1:0] nxt_wr_ptr;
	logic [PTR_W-1:0] nxt_rd_ptr;
	logic [CNT_W-1:0] nxt_count;
	logic             push;
	logic             pop;

	// Honest full and empty straight from the occupancy count
	assign in_ready  = (count_ff != CNT_W'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem[rd_ptr_ff];

	always_comb begin
		push       = in_valid && in_ready;
		pop        = out_valid && out_ready;
		nxt_wr_ptr = push ? PTR_W'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
		nxt_rd_ptr = pop ? PTR_W'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
		nxt_count  = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else if (clk_en) begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

endmodule : word_fifo

// Functional notes
// - Reset low clears all control and state
// - Bit clock equals master over divisor product
// - Output bits launch on bit-clock rising edge
// - Data output floats when idle or disabled
// - One-period sync precedes each word, MSB first
// - Output sync changes on rising edges only, or when the port is disabled
// - Output sync floats while port disabled
// - Input sync sampled on falling edge, enabled
// - Input bits captured on falling edge, enabled
// - Disable floats outputs, ignores inputs, stops clock
// - Re-enable keeps data, restarts timing state
module codec_serial_port_framing (
	input  wire logic                                     ref_clk,
	input  wire logic                                     rst_n,
	input  wire logic                                     clk_en,
	input  wire logic                                     serial_port_enable,
	input  wire logic [codec_serial_pkg::MDIV_SEL_W-1:0]  mclk_div_sel,
	input  wire logic [codec_serial_pkg::SDIV_SEL_W-1:0]  sclk_div_sel,
	input  wire logic                                     tx_valid,
	input  wire logic [codec_serial_pkg::WORD_BITS-1:0]   tx_data,
	output logic                                          tx_ready,
	output logic                                          serial_bit_clock,
	output logic                                          serial_data_out,
	output logic                                          serial_data_out_oe,
	output logic                                          output_frame_sync,
	output logic                                          output_frame_sync_oe,
	input  wire logic                                     serial_data_in,
	input  wire logic                                     input_frame_sync,
	output logic [codec_serial_pkg::WORD_BITS-1:0]        rx_word,
	output logic                                          rx_valid
);
	localparam int unsigned HW = codec_serial_pkg::HALF_W;
	localparam int unsigned CW = codec_serial_pkg::CNT_W;
	localparam int unsigned WB = codec_serial_pkg::WORD_BITS;

	// Bit clock generation
	logic [HW-1:0] half_cnt_ff;
	logic [HW-1:0] nxt_half_cnt;
	logic          sclk_ff;
	logic          nxt_sclk;
	logic [HW-1:0] mdiv;
	logic [HW-1:0] sdiv;
	logic [HW-1:0] half_len;
	logic          tick;
	logic          rise_ev;
	logic          fall_ev;
	logic          port_on;

	// Transmit path
	codec_serial_pkg::tx_state_t tx_state_ff;
	codec_serial_pkg::tx_state_t nxt_tx_state;
	logic [WB-1:0] tx_shift_ff;
	logic [WB-1:0] nxt_tx_shift;
	logic [CW-1:0] tx_cnt_ff;
	logic [CW-1:0] nxt_tx_cnt;
	logic          sdo_ff;
	logic          nxt_sdo;
	logic          sdo_oe_ff;
	logic          nxt_sdo_oe;
	logic          fs_ff;
	logic          nxt_fs;
	logic          fs_oe_ff;
	logic          nxt_fs_oe;
	logic          fifo_valid;
	logic [WB-1:0] fifo_data;
	logic          fifo_pop;

	// Receive path
	codec_serial_pkg::rx_state_t rx_state_ff;
	codec_serial_pkg::rx_state_t nxt_rx_state;
	logic [WB-1:0] rx_shift_ff;
	logic [WB-1:0] nxt_rx_shift;
	logic [CW-1:0] rx_cnt_ff;
	logic [CW-1:0] nxt_rx_cnt;
	logic [WB-1:0] rx_word_ff;
	logic [WB-1:0] nxt_rx_word;
	logic          rx_valid_ff;
	logic          nxt_rx_valid;

	assign port_on = serial_port_enable;

	// Word buffer survives a port disable; only timing state restarts
	word_fifo #(
		.WIDTH (WB),
		.DEPTH (codec_serial_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.in_valid  (tx_valid),
		.in_data   (tx_data),
		.in_ready  (tx_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	// ref_clk is the externally supplied master clock
	always_comb begin
		mdiv     = HW'(mclk_div_sel) + codec_serial_pkg::MDIV_BASE;
		sdiv     = HW'(codec_serial_pkg::SDIV_BASE << sclk_div_sel);
		// Product can reach one past the counter width, so form it one bit wider
		half_len = HW'(({1'b0, mdiv} * {1'b0, sdiv}) >> 1);
		// A divisor change mid-period must not let the counter run past its end
		tick     = port_on && (half_cnt_ff >= half_len - 1'b1);
		rise_ev  = tick && !sclk_ff;
		fall_ev  = tick && sclk_ff;
		nxt_half_cnt = tick ? codec_serial_pkg::HALF_RST : half_cnt_ff + 1'b1;
		nxt_sclk     = tick ? !sclk_ff : sclk_ff;
		if (!port_on) begin
			nxt_half_cnt = codec_serial_pkg::HALF_RST;
			nxt_sclk     = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt_ff <= codec_serial_pkg::HALF_RST;
			sclk_ff     <= 1'b0;
		end else if (clk_en) begin
			half_cnt_ff <= nxt_half_cnt;
			sclk_ff     <= nxt_sclk;
		end
	end

	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_shift = tx_shift_ff;
		nxt_tx_cnt   = tx_cnt_ff;
		nxt_sdo      = sdo_ff;
		nxt_sdo_oe   = sdo_oe_ff;
		nxt_fs       = fs_ff;
		nxt_fs_oe    = port_on;
		fifo_pop     = 1'b0;
		if (!port_on) begin
			nxt_tx_state = codec_serial_pkg::TX_IDLE;
			nxt_tx_cnt   = codec_serial_pkg::CNT_RST;
			nxt_sdo      = 1'b0;
			nxt_sdo_oe   = 1'b0;
			nxt_fs       = 1'b0;
		end else if (rise_ev) begin
			// While enabled, every launch, sync change and data float change waits for a rising edge
			nxt_fs = 1'b0;
			unique case (tx_state_ff)
				codec_serial_pkg::TX_IDLE: begin
					nxt_sdo_oe = 1'b0;
				end
				codec_serial_pkg::TX_SYNC: begin
					nxt_tx_state = codec_serial_pkg::TX_SHIFT;
					nxt_tx_cnt   = codec_serial_pkg::CNT_LAST;
					nxt_sdo      = tx_shift_ff[codec_serial_pkg::MSB_POS];
					nxt_sdo_oe   = 1'b1;
					nxt_tx_shift = {tx_shift_ff[WB-2:0], 1'b0};
				end
				codec_serial_pkg::TX_SHIFT: begin
					nxt_tx_cnt   = tx_cnt_ff - 1'b1;
					nxt_sdo      = tx_shift_ff[codec_serial_pkg::MSB_POS];
					nxt_tx_shift = {tx_shift_ff[WB-2:0], 1'b0};
					if (tx_cnt_ff == codec_serial_pkg::CNT_RST + 1'b1) begin
						nxt_tx_state = codec_serial_pkg::TX_SHIFT;
					end else if (tx_cnt_ff == codec_serial_pkg::CNT_RST) begin
						nxt_tx_state = codec_serial_pkg::TX_IDLE;
						nxt_tx_cnt   = codec_serial_pkg::CNT_RST;
						nxt_sdo_oe   = 1'b0;
					end
				end
				default: begin
					nxt_tx_state = codec_serial_pkg::TX_IDLE;
					nxt_sdo_oe   = 1'b0;
				end
			endcase
			// A waiting word starts its sync period as the last bit ends
			if ((nxt_tx_state == codec_serial_pkg::TX_IDLE) && fifo_valid) begin
				nxt_tx_state = codec_serial_pkg::TX_SYNC;
				nxt_tx_shift = fifo_data;
				nxt_fs       = 1'b1;
				fifo_pop     = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_ff <= codec_serial_pkg::TX_IDLE;
			tx_shift_ff <= codec_serial_pkg::WORD_RST;
			tx_cnt_ff   <= codec_serial_pkg::CNT_RST;
			sdo_ff      <= 1'b0;
			sdo_oe_ff   <= 1'b0;
			fs_ff       <= 1'b0;
			fs_oe_ff    <= 1'b0;
		end else if (clk_en) begin
			tx_state_ff <= nxt_tx_state;
			tx_shift_ff <= nxt_tx_shift;
			tx_cnt_ff   <= nxt_tx_cnt;
			sdo_ff      <= nxt_sdo;
			sdo_oe_ff   <= nxt_sdo_oe;
			fs_ff       <= nxt_fs;
			fs_oe_ff    <= nxt_fs_oe;
		end
	end

	always_comb begin
		nxt_rx_state = rx_state_ff;
		nxt_rx_shift = rx_shift_ff;
		nxt_rx_cnt   = rx_cnt_ff;
		nxt_rx_word  = rx_word_ff;
		nxt_rx_valid = 1'b0;
		if (!port_on) begin
			nxt_rx_state = codec_serial_pkg::RX_IDLE;
			nxt_rx_cnt   = codec_serial_pkg::CNT_RST;
		end else if (fall_ev) begin
			unique case (rx_state_ff)
				codec_serial_pkg::RX_IDLE: begin
					if (input_frame_sync) begin
						nxt_rx_state = codec_serial_pkg::RX_SHIFT;
						nxt_rx_cnt   = codec_serial_pkg::CNT_LAST;
					end
				end
				codec_serial_pkg::RX_SHIFT: begin
					nxt_rx_shift = {rx_shift_ff[WB-2:0], serial_data_in};
					nxt_rx_cnt   = rx_cnt_ff - 1'b1;
					if (rx_cnt_ff == codec_serial_pkg::CNT_RST) begin
						nxt_rx_word  = {rx_shift_ff[WB-2:0], serial_data_in};
						nxt_rx_valid = 1'b1;
						nxt_rx_state = codec_serial_pkg::RX_IDLE;
						if (input_frame_sync) begin
							nxt_rx_state = codec_serial_pkg::RX_SHIFT;
							nxt_rx_cnt   = codec_serial_pkg::CNT_LAST;
						end
					end
				end
				default: begin
					nxt_rx_state = codec_serial_pkg::RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_ff <= codec_serial_pkg::RX_IDLE;
			rx_shift_ff <= codec_serial_pkg::WORD_RST;
			rx_cnt_ff   <= codec_serial_pkg::CNT_RST;
			rx_word_ff  <= codec_serial_pkg::WORD_RST;
			rx_valid_ff <= 1'b0;
		end else if (clk_en) begin
			rx_state_ff <= nxt_rx_state;
			rx_shift_ff <= nxt_rx_shift;
			rx_cnt_ff   <= nxt_rx_cnt;
			rx_word_ff  <= nxt_rx_word;
			rx_valid_ff <= nxt_rx_valid;
		end
	end

	assign serial_bit_clock     = sclk_ff;
	assign serial_data_out      = sdo_ff;
	assign serial_data_out_oe   = sdo_oe_ff;
	assign output_frame_sync    = fs_ff;
	assign output_frame_sync_oe = fs_oe_ff;
	assign rx_word              = rx_word_ff;
	assign rx_valid             = rx_valid_ff;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sync_width_a: assert property (clk_en && fs_ff && rise_ev && port_on |=> !fs_ff)
		else $error("Output sync wider than one bit period");
	sync_then_msb_a: assert property (clk_en && port_on && rise_ev && fifo_pop
		|=> tx_state_ff == codec_serial_pkg::TX_SYNC
		&& tx_shift_ff[codec_serial_pkg::MSB_POS] == $past(fifo_data[WB-1]))
		else $error("Word does not start with its MSB");
	msb_first_a: assert property (clk_en && port_on && rise_ev
		&& tx_state_ff == codec_serial_pkg::TX_SYNC
		|=> sdo_oe_ff && sdo_ff == $past(tx_shift_ff[codec_serial_pkg::MSB_POS]))
		else $error("First bit after sync is not the MSB");
	sdo_float_a: assert property (clk_en && !port_on |=> !sdo_oe_ff)
		else $error("Data output driven while disabled");
	sync_float_a: assert property (clk_en && !port_on |=> !fs_oe_ff)
		else $error("Frame sync driven while disabled");
	clock_gated_a: assert property (clk_en && !port_on |=> !sclk_ff && half_cnt_ff == '0)
		else $error("Bit clock running while disabled");
	sync_edge_a: assert property ($changed(fs_ff) |-> $past(rise_ev) || !$past(port_on))
		else $error("Frame sync moved off a rising edge");
	data_edge_a: assert property ($changed(sdo_ff) |-> $past(rise_ev) || !$past(port_on))
		else $error("Data output moved off a rising edge");
	word_len_a: assert property (clk_en && port_on && rise_ev
		&& tx_state_ff == codec_serial_pkg::TX_SYNC |=> tx_cnt_ff == codec_serial_pkg::CNT_LAST)
		else $error("Word length not sixteen bits");
	restart_a: assert property (clk_en && !port_on
		|=> tx_state_ff == codec_serial_pkg::TX_IDLE && rx_state_ff == codec_serial_pkg::RX_IDLE)
		else $error("Timing state not restarted on disable");
	rx_sync_a: assert property (clk_en && port_on && fall_ev && input_frame_sync
		&& rx_state_ff == codec_serial_pkg::RX_IDLE |=> rx_state_ff == codec_serial_pkg::RX_SHIFT)
		else $error("Input sync missed");
	rx_capture_a: assert property (rx_valid_ff |-> $past(fall_ev) && $past(port_on))
		else $error("Input word completed off a falling edge");
	half_bound_a: assert property (port_on && $stable(mclk_div_sel) && $stable(sclk_div_sel)
		|-> half_cnt_ff < half_len)
		else $error("Bit clock divider overran");

	word_sent_c: cover property (tx_state_ff == codec_serial_pkg::TX_SHIFT
		&& tx_cnt_ff == codec_serial_pkg::CNT_RST && rise_ev && fifo_valid);
	word_recv_c: cover property (rx_valid_ff);
	disable_mid_c: cover property (tx_state_ff == codec_serial_pkg::TX_SHIFT && !port_on);
	fifo_full_c: cover property (!tx_ready);

endmodule : codec_serial_port_framing

// ---- verilog/codec_serial_pkg.sv ----
package codec_serial_pkg;

	// Word and buffer shape
	localparam int unsigned WORD_BITS  = 16;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned FIFO_DEPTH = 8;

	// Divider select fields and the bit-clock half-period counter
	localparam int unsigned MDIV_SEL_W = 3;
	localparam int unsigned SDIV_SEL_W = 2;
	localparam int unsigned HALF_W     = 7;

	// Master divisor is select+1 (1..8); bit-clock divisor is 2 << select (2..16)
	localparam logic [HALF_W-1:0] MDIV_BASE = 7'h01;
	localparam logic [HALF_W-1:0] SDIV_BASE = 7'h02;

	// Reset values and the bit-count load value
	localparam logic [HALF_W-1:0]    HALF_RST  = 7'h00;
	localparam logic [CNT_W-1:0]     CNT_RST   = 4'h0;
	localparam logic [CNT_W-1:0]     CNT_LAST  = 4'hf;
	localparam logic [WORD_BITS-1:0] WORD_RST  = 16'h0000;

	// Bit positions
	localparam int unsigned MSB_POS = WORD_BITS - 1;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_SYNC  = 3'b010,
		TX_SHIFT = 3'b100
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b01,
		RX_SHIFT = 2'b10
	} rx_state_t;

endpackage : codec_serial_pkg

// ---- verif/host_port_model.sv ----
`timescale 1ns/1ps
module host_port_model (
	input  wire logic rst_n,
	input  wire logic serial_port_enable,
	input  wire logic serial_bit_clock,
	input  wire logic serial_data_out,
	input  wire logic serial_data_out_oe,
	input  wire logic output_frame_sync,
	input  wire logic output_frame_sync_oe,
	output logic      serial_data_in,
	output logic      input_frame_sync
);
	logic [15:0] txq[$];
	logic [15:0] rxq[$];
	logic [15:0] cur_ff;
	logic [15:0] shf_ff;
	int          tx_bits;
	int          rx_bits;
	int          n_err;

	// Launch on the rise so the device sees settled levels at its falling capture
	always @(posedge serial_bit_clock or negedge rst_n or negedge serial_port_enable) begin
		if (!rst_n || !serial_port_enable) begin
			tx_bits = 0;
			input_frame_sync <= 1'b0;
			serial_data_in <= 1'b0;
		end else begin
			// Idle data line is not held: it toggles every bit
			serial_data_in <= (tx_bits > 0) ? cur_ff[tx_bits-1] : ~serial_data_in;
			input_frame_sync <= (tx_bits <= 1) && (txq.size() > 0);
			if ((tx_bits <= 1) && (txq.size() > 0)) begin
				cur_ff <= txq.pop_front();
				tx_bits = 16;
			end else if (tx_bits > 0) begin
				tx_bits = tx_bits - 1;
			end
		end
	end

	always @(negedge serial_bit_clock or negedge rst_n or negedge serial_port_enable) begin
		if (!rst_n || !serial_port_enable) begin
			rx_bits = 0;
		end else begin
			if ((rx_bits > 0) !== serial_data_out_oe) n_err++;
			if ((rx_bits > 0) && output_frame_sync) n_err++;
			if (rx_bits > 0) begin
				shf_ff = {shf_ff[14:0], serial_data_out};
				rx_bits--;
				if (rx_bits == 0) rxq.push_back(shf_ff);
			end else if (output_frame_sync_oe && output_frame_sync) begin
				rx_bits = 16;
			end
		end
	end

	// Output lines may move only together with a rising bit clock
	always @(output_frame_sync or serial_data_out) begin
		#1;
		if (rst_n && serial_port_enable && serial_bit_clock !== 1'b1) n_err++;
	end
endmodule : host_port_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic        ref_clk, rst_n, clk_en, serial_port_enable, tx_valid, tx_ready;
	logic        serial_bit_clock, serial_data_out, serial_data_out_oe, rx_valid;
	logic        output_frame_sync, output_frame_sync_oe, serial_data_in, input_frame_sync;
	logic [2:0]  mclk_div_sel;
	logic [1:0]  sclk_div_sel;
	logic [15:0] tx_data, rx_word;
	logic [15:0] rxq[$];
	int          n_mismatch, n_checks;
	realtime     t0;

	codec_serial_port_framing u_dut (.ref_clk, .rst_n, .clk_en, .serial_port_enable,
		.mclk_div_sel, .sclk_div_sel, .tx_valid, .tx_data, .tx_ready, .serial_bit_clock,
		.serial_data_out, .serial_data_out_oe, .output_frame_sync, .output_frame_sync_oe,
		.serial_data_in, .input_frame_sync, .rx_word, .rx_valid);
	host_port_model u_host (.rst_n, .serial_port_enable, .serial_bit_clock, .serial_data_out,
		.serial_data_out_oe, .output_frame_sync, .output_frame_sync_oe, .serial_data_in,
		.input_frame_sync);

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (rx_valid === 1'b1) rxq.push_back(rx_word);

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic put(input int n, input logic [15:0] base);
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 400 && tx_ready !== 1'b1; k++) tick(1);
			tx_data = base + 16'(i) * 16'h1357;
			tx_valid = 1'b1;
			tick(1);
		end
		tx_valid = 1'b0;
	endtask : put

	task automatic wait_host(input int n);
		for (int k = 0; k < 5000 && u_host.rxq.size() < n; k++) tick(1);
	endtask : wait_host

	task automatic t_div;
		logic held;
		for (int m = 0; m < 8; m++)
			for (int s = 0; s < 4; s++) begin
				mclk_div_sel = 3'(m);
				sclk_div_sel = 2'(s);
				repeat (2) @(posedge serial_bit_clock);
				t0 = $realtime;
				@(posedge serial_bit_clock);
				check(32'(int'(($realtime - t0) / 20.0)), 32'((m + 1) * (2 << s)));
				tick(1);
			end
		mclk_div_sel = 3'h0;
		sclk_div_sel = 2'h1;
		tick(4);
		held = serial_bit_clock;
		clk_en = 1'b0;
		tick(40);
		check(serial_bit_clock, held);
		clk_en = 1'b1;
		$display("test divider done");
	endtask : t_div

	task automatic t_words;
		put(3, 16'h8001);
		u_host.txq.push_back(16'h8001);
		u_host.txq.push_back(16'h7ffe);
		u_host.txq.push_back(16'ha5c3);
		wait_host(3);
		for (int i = 0; i < 3; i++) check(u_host.rxq.pop_front(), 16'h8001 + i * 16'h1357);
		for (int k = 0; k < 500 && rxq.size() < 3; k++) tick(1);
		check(rxq.pop_front(), 16'h8001);
		check(rxq.pop_front(), 16'h7ffe);
		check(rxq.pop_front(), 16'ha5c3);
		$display("test words done");
	endtask : t_words

	task automatic t_fifo;
		serial_port_enable = 1'b0;
		put(8, 16'h1000);
		tick(1);
		check(tx_ready, 1'b0);
		tx_data = 16'hffff;
		tx_valid = 1'b1;
		tick(4);
		tx_valid = 1'b0;
		check(serial_bit_clock, 1'b0);
		serial_port_enable = 1'b1;
		wait_host(8);
		tick(100);
		check(u_host.rxq.size(), 8);
		for (int i = 0; i < 8; i++) check(u_host.rxq.pop_front(), 16'h1000 + i * 16'h1357);
		$display("test fifo done");
	endtask : t_fifo

	task automatic t_abort;
		u_host.txq.push_back(16'h3c5a);
		put(2, 16'h4242);
		for (int k = 0; k < 500 && u_host.rx_bits != 8; k++) tick(1);
		serial_port_enable = 1'b0;
		tick(20);
		check({serial_bit_clock, serial_data_out_oe, output_frame_sync_oe}, 3'h0);
		serial_port_enable = 1'b1;
		u_host.txq.push_back(16'h0ff0);
		wait_host(1);
		for (int k = 0; k < 500 && rxq.size() < 1; k++) tick(1);
		tick(100);
		check(u_host.rxq.pop_front(), 16'h4242 + 16'h1357);
		check(rxq.size(), 1);
		check(rxq.pop_front(), 16'h0ff0);
		$display("test abort done");
	endtask : t_abort

	task automatic t_rereset;
		serial_port_enable = 1'b0;
		put(2, 16'h5555);
		rst_n = 1'b0;
		tick(2);
		check({tx_ready, serial_bit_clock, output_frame_sync_oe, rx_valid}, 4'h8);
		rst_n = 1'b1;
		serial_port_enable = 1'b1;
		tick(200);
		check(u_host.rxq.size(), 0);
		check(u_host.n_err, 0);
		$display("test reset done");
	endtask : t_rereset

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	initial begin
		#1_500_000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		serial_port_enable = 1'b1;
		tx_valid = 1'b0;
		tx_data = 16'h0000;
		mclk_div_sel = 3'h0;
		sclk_div_sel = 2'h0;
		tick(3);
		check({tx_ready, serial_bit_clock, serial_data_out_oe, output_frame_sync_oe}, 4'h8);
		tick(3);
		rst_n = 1'b1;
		t_div();
		t_words();
		t_fifo();
		t_abort();
		t_rereset();
		stop_test();
	end
endmodule : testbench
